// ### src/pwm_common.sv
// pwm_common.sv
// shared control core of a six-channel pwm unit: prescaler, 10-bit period counter,
// output inversion and pin enables, overflow flag and interrupt request
// assumes clk is the high-speed oscillator, register requests and raw channel
// waveforms come from logic on the same clock
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "pwm_common_map.svh"

module pwm_common (
  input  wire logic                      clk,            // fosc
  input  wire logic                      reset,          // async, active high
  input  wire pwm_common_pkg::reg_req_t  req,            // register request
  input  wire logic [5:0]                chan_wave,      // raw channel waveforms
  output logic [7:0]                     rdata,          // read data, cycle after read
  output logic [9:0]                     count,          // shared counter value
  output logic                           pwm_tick,       // one pwm clock this cycle
  output logic [5:0]                     pin_out,        // channel pin levels
  output logic [5:0]                     pin_oe,         // channel pin drive enables
  output logic                           irq,            // pwm interrupt request
  output logic                           irq_high        // request at high priority
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  pwm_common_pkg::core_state_t s_r;
  pwm_common_pkg::core_state_t s_nxt;

  pwm_common_pkg::clk_sel_t    clk_sel;
  logic [4:0]                  pre_last;
  logic                        run;
  logic                        tick;
  logic                        wrap;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = `RST_BYTE;

    clk_sel = pwm_common_pkg::clk_sel_t'(s_r.cfg[`CFG_CLK_SEL_HI:`CFG_CLK_SEL_LO]);
    unique case (clk_sel)
      pwm_common_pkg::CLK_DIV1: pre_last = `PRE_LAST_DIV1;
      pwm_common_pkg::CLK_DIV2: pre_last = `PRE_LAST_DIV2;
      pwm_common_pkg::CLK_DIV8: pre_last = `PRE_LAST_DIV8;
      pwm_common_pkg::CLK_DIV32: pre_last = `PRE_LAST_DIV32;
    endcase

    // prescaler and counter run regardless of pin enables
    run  = s_r.ctrl[`CTRL_RUN_BIT];
    tick = run && (s_r.pre >= pre_last);
    // >= also catches a period lowered below the running count
    wrap = tick && (s_r.cnt >= s_r.period);

    if (!run) begin
      s_nxt.pre = 5'h00;
      s_nxt.cnt = 10'h000;
    end else if (tick) begin
      s_nxt.pre = 5'h00;
      s_nxt.cnt = wrap ? 10'h000 : s_r.cnt + 10'h001;
    end else begin
      s_nxt.pre = s_r.pre + 5'h01;
    end
    s_nxt.tick = tick;

    // register writes
    if (req.wr) begin
      unique case (req.addr)
        `OFS_IRQ_ENABLE_ONE:   s_nxt.ie1 = req.wdata[`IRQ_IMPL_WIDTH-1:0];
        `OFS_IRQ_PRIORITY_ONE: s_nxt.ip1 = req.wdata[`IRQ_IMPL_WIDTH-1:0];
        `OFS_CLK_INV_CFG:      s_nxt.cfg = req.wdata;
        `OFS_ENABLE_FLAG_CTRL: begin
          s_nxt.ctrl = req.wdata;
          // flag clears on a written zero only; a written one leaves it
          s_nxt.ctrl[`CTRL_FLAG_BIT] = s_r.ctrl[`CTRL_FLAG_BIT] & req.wdata[`CTRL_FLAG_BIT];
        end
        `OFS_PERIOD_HIGH: begin
          s_nxt.prd_hi = req.wdata;
          // high byte write commits, so low bits must already be in place
          s_nxt.period = {req.wdata, s_r.dtya[`DTYA_PRD_HI:`DTYA_PRD_LO]};
        end
        `OFS_DUTY_LOW_A:       s_nxt.dtya = req.wdata;
        default: ;
      endcase
    end

    // a wrap in the clearing cycle still sets the flag
    if (wrap) begin
      s_nxt.ctrl[`CTRL_FLAG_BIT] = 1'b1;
    end

    // register reads, data stand in the next cycle
    if (req.rd) begin
      unique case (req.addr)
        `OFS_IRQ_ENABLE_ONE:   s_nxt.rdata = {3'h0, s_r.ie1};
        `OFS_IRQ_PRIORITY_ONE: s_nxt.rdata = {3'h0, s_r.ip1};
        `OFS_CLK_INV_CFG:      s_nxt.rdata = s_r.cfg;
        `OFS_ENABLE_FLAG_CTRL: s_nxt.rdata = s_r.ctrl;
        `OFS_PERIOD_HIGH:      s_nxt.rdata = s_r.prd_hi;
        `OFS_DUTY_LOW_A:       s_nxt.rdata = s_r.dtya;
        default:               s_nxt.rdata = `RST_BYTE;
      endcase
    end

    // per-channel output stage; enables act independent of run enable
    for (int i = 0; i < 6; i++) begin
      s_nxt.pin_out[i] = chan_wave[i] ^ s_r.cfg[i];
      s_nxt.pin_oe[i]  = s_r.ctrl[i];
    end

    s_nxt.irq      = s_nxt.ctrl[`CTRL_FLAG_BIT] & s_nxt.ie1[`IRQ_PWM_BIT];
    s_nxt.irq_high = s_nxt.irq & s_nxt.ip1[`IRQ_PWM_BIT];
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata    = s_r.rdata;
  assign count    = s_r.cnt;
  assign pwm_tick = s_r.tick;
  assign pin_out  = s_r.pin_out;
  assign pin_oe   = s_r.pin_oe;
  assign irq      = s_r.irq;
  assign irq_high = s_r.irq_high;

endmodule : pwm_common

// ### src/pwm_common_map.svh
// pwm_common_map.svh
// offsets, field positions, reset values and prescaler counts of the shared pwm control core
// assumes an 8-bit special function register space addressed by an 8-bit address
`ifndef PWM_COMMON_MAP_SVH
`define PWM_COMMON_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_IRQ_ENABLE_ONE   8'hA9
`define OFS_IRQ_PRIORITY_ONE 8'hB9
`define OFS_CLK_INV_CFG      8'hD1
`define OFS_ENABLE_FLAG_CTRL 8'hD2
`define OFS_PERIOD_HIGH      8'hD3
`define OFS_DUTY_LOW_A       8'hD4

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CFG_CLK_SEL_HI   7
`define CFG_CLK_SEL_LO   6
`define CTRL_RUN_BIT     7
`define CTRL_FLAG_BIT    6
`define DTYA_PRD_HI      7
`define DTYA_PRD_LO      6
`define IRQ_PWM_BIT      1
`define IRQ_IMPL_WIDTH   5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_IRQ_BITS     5'h00
`define RST_PERIOD       10'h000

// ----------------------------------------------------------------------------
// prescaler terminal counts: fosc/1, /2, /8, /32
// ----------------------------------------------------------------------------
`define PRE_LAST_DIV1    5'h00
`define PRE_LAST_DIV2    5'h01
`define PRE_LAST_DIV8    5'h07
`define PRE_LAST_DIV32   5'h1F

`endif

// ### src/pwm_common_pkg.sv
// pwm_common_pkg.sv
// types shared by the pwm control core and its bench
// assumes pwm_common_map.svh is on the include path
package pwm_common_pkg;

  typedef enum logic [1:0] {
    CLK_DIV1,
    CLK_DIV2,
    CLK_DIV8,
    CLK_DIV32
  } clk_sel_t;

  // one register bus request, sampled on the rising edge
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // whole state of the core
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic [7:0] prd_hi;
    logic [7:0] dtya;
    logic [4:0] ie1;
    logic [4:0] ip1;
    logic [9:0] period;
    logic [4:0] pre;
    logic [9:0] cnt;
    logic [7:0] rdata;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic       tick;
    logic       irq;
    logic       irq_high;
  } core_state_t;

endpackage : pwm_common_pkg

// ### verif/pwm_common_chk_chk.sv
// pwm_common_chk_chk.sv
// port checks of the pwm control core
// assumes it is bound into pwm_common
`timescale 1ns/1ps
`include "pwm_common_map.svh"
module pwm_common_chk (
  input wire logic                     clk,     // fosc
  input wire logic                     reset,   // async, high
  input wire pwm_common_pkg::reg_req_t req,     // bus request
  input wire logic [7:0]               rdata,   // read data
  input wire logic [9:0]               count,   // counter
  input wire logic [5:0]               pin_oe,  // pin enables
  input wire logic                     irq,     // request
  input wire logic                     irq_high // high priority
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_ctrl_wr;
    req.wr && req.addr == `OFS_ENABLE_FLAG_CTRL;
  endsequence
  sequence s_stop;
    s_ctrl_wr ##0 !req.wdata[`CTRL_RUN_BIT];
  endsequence
  chk_count_step: assert property (count != $past(count) |-> count == $past(count) + 10'h001 || count == 10'h000)
    else $error("counter jumped");
  chk_wrap_irq: assert property ($rose(irq) && !$past(req.wr) |-> count == 10'h000)
    else $error("irq rose off a wrap");
  chk_flag_hold: assert property (irq && !req.wr |=> irq)
    else $error("irq dropped without a write");
  chk_prio_gate: assert property (!irq && !$past(irq) |-> !irq_high)
    else $error("priority without request");
  chk_idle_rdata: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  chk_stop_zero: assert property (s_stop |-> ##2 count == 10'h000)
    else $error("counter not zeroed on stop");
  chk_oe_follow: assert property (s_ctrl_wr |-> ##2 pin_oe == $past(req.wdata[5:0], 2))
    else $error("pin enables not taken");
  chk_hole_read: assert property (req.rd && req.addr[7:4] == 4'h0 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : pwm_common_chk
bind pwm_common pwm_common_chk u_chk (.clk(clk), .reset(reset), .req(req), .rdata(rdata), .count(count),
  .pin_oe(pin_oe), .irq(irq), .irq_high(irq_high));

// ### verif/pwm_pin_model.sv
// pwm_pin_model.sv
// pad model of the six channel pins
// assumes pins carry a weak pull-up when the unit releases them
`timescale 1ns/1ps
module pwm_pin_model (
  input  wire logic [5:0] pin_out, // channel levels
  input  wire logic [5:0] pin_oe,  // drive enables
  output wire logic [5:0] pad      // resolved pad levels
);
  // a released pad floats to the pull-up, never the last driven level
  assign pad = (pin_out & pin_oe) | ~pin_oe;
endmodule : pwm_pin_model

// ### verif/tb_top.sv
// tb_top.sv
// self-checking bench of the pwm control core
// assumes the core, its checker and the pin model are compiled before it
`timescale 1ns/1ps
`include "pwm_common_map.svh"
module tb_top;
  logic                     clk, reset, pwm_tick, irq, irq_high;
  pwm_common_pkg::reg_req_t req;
  logic [5:0]               chan_wave, pin_out, pin_oe, pad, oe;
  logic [7:0]               rdata, inv;
  logic [9:0]               count;
  int                       fails, n_compared, seed, g, sel;
  pwm_common u_dut (.clk(clk), .reset(reset), .req(req), .chan_wave(chan_wave), .rdata(rdata), .count(count),
    .pwm_tick(pwm_tick), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .irq_high(irq_high));
  pwm_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 chk({2'b00, rdata}, {2'b00, exp});
  endtask : rd
  function int gap_exp(int s, int p);
    return (p + 1) * (s == 0 ? 1 : s == 1 ? 2 : s == 2 ? 8 : 32);
  endfunction : gap_exp
  // clocks from one wrap to the next; gives up after a bounded wait
  task gap(output int n);
    int z, k;
    logic [9:0] last;
    z = 0;
    n = 0;
    last = count;
    for (k = 0; k < 3000 && z < 2; k++) begin
      @(posedge clk) #1 n++;
      if (count == 10'h000 && last != 10'h000) begin
        z++;
        if (z == 1) n = 0;
      end
      last = count;
    end
    if (z < 2) begin
      fails++;
      results();
    end
  endtask : gap
  initial begin
    seed = 1;
    fails = 0;
    n_compared = 0;
    req = '0;
    chan_wave = 6'h00;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(`OFS_CLK_INV_CFG, 8'h00);
    rd(`OFS_ENABLE_FLAG_CTRL, 8'h00);
    rd(8'h00, 8'h00);
    wr(`OFS_IRQ_ENABLE_ONE, 8'hFF);
    rd(`OFS_IRQ_ENABLE_ONE, 8'h1F);
    wr(`OFS_IRQ_PRIORITY_ONE, 8'h02);
    wr(`OFS_DUTY_LOW_A, 8'hC0);
    wr(`OFS_PERIOD_HIGH, 8'h01);
    // every clock divider, pins released, so the unit runs as a bare timer
    for (sel = 0; sel < 4; sel++) begin
      inv = $random(seed);
      wr(`OFS_CLK_INV_CFG, {sel[1:0], inv[5:0]});
      wr(`OFS_ENABLE_FLAG_CTRL, 8'h80);
      gap(g);
      chk(10'(g), 10'(gap_exp(sel, 7)));
      chk({9'h000, pwm_tick}, 10'h001);
      @(posedge clk) chan_wave <= 6'($random(seed));
      repeat (2) @(posedge clk);
      #1 chk({4'h0, pin_out}, {4'h0, chan_wave ^ inv[5:0]});
      chk({8'h00, irq, irq_high}, 10'h003);
      rd(`OFS_ENABLE_FLAG_CTRL, 8'hC0);
      wr(`OFS_ENABLE_FLAG_CTRL, 8'h00);
      #1 chk({9'h000, irq}, 10'h000);
      repeat (2) @(posedge clk);
      #1 chk(count, 10'h000);
    end
    oe = 6'($random(seed));
    wr(`OFS_ENABLE_FLAG_CTRL, {2'b00, oe});
    repeat (2) @(posedge clk);
    #1 chk({4'h0, pad}, {4'h0, ((chan_wave ^ inv[5:0]) & oe) | ~oe});
    results();
  end
endmodule : tb_top
